// ---- bench/sl1c_mem_model.sv ----
// line-wide main memory that answers line reads and writes after a set latency
`timescale 1ns/1ns
module sl1c_mem_model (
    input  wire logic                   clk,
    input  wire logic                   mem_req,
    input  wire sl1c_pkg::sl1c_memreq_t mem_cmd,
    output logic                        mem_ack,
    output logic [127:0]                mem_rdata,
    input  wire logic [3:0]             lat,
    output int                          rd_cnt,
    output int                          wr_cnt
);
    logic [127:0] mem [logic [31:0]];
    int           cnt = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = '0;
        rd_cnt = 0;
        wr_cnt = 0;
    end
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        if (mem_ack || !mem_req || cnt < int'(lat)) begin
            mem_rdata <= ~mem_rdata;  // no line is valid outside the ack cycle
            cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
        end else begin
            mem_ack <= 1'b1;
            cnt <= 0;
            if (mem_cmd.we) begin
                mem[mem_cmd.addr] = mem_cmd.wdata;
                wr_cnt <= wr_cnt + 1;
            end else begin
                rd_cnt <= rd_cnt + 1;
                mem_rdata <= mem.exists(mem_cmd.addr) ? mem[mem_cmd.addr] : {4{32'h5A5A0000}}
                    ^ {mem_cmd.addr + 32'hC, mem_cmd.addr + 32'h8, mem_cmd.addr + 32'h4, mem_cmd.addr};
            end
        end
    end
endmodule

// ---- bench/split_l1_cache_tb_top.sv ----
// self-checking bench of the split level-one cache
`timescale 1ns/1ns
module split_l1_cache_tb_top;
    typedef struct packed {
        logic        we;
        logic [3:0]  be;
        logic [31:0] wd;
        logic [31:0] va;
        logic [31:0] pa;
        logic [7:0]  rd;
        logic [7:0]  wr;
    } sl1c_row_t;
    logic                   clk = 1'b0, rst = 1'b1, i_req = 1'b0, d_req = 1'b0, op_req = 1'b0;
    sl1c_pkg::sl1c_ireq_t   i_req_data = '0;
    sl1c_pkg::sl1c_dreq_t   d_req_data = '0;
    sl1c_pkg::sl1c_opreq_t  op_req_data = '0;
    logic                   i_ready, i_rvalid, d_ready, d_rvalid, op_ready, op_done, mem_req, mem_ack;
    logic [31:0]            i_rdata, d_rdata, i_exp, d_exp, w;
    logic [127:0]           mem_rdata;
    sl1c_pkg::sl1c_memreq_t mem_cmd;
    logic [3:0]             lat = 4'h0;
    logic                   i_chk = 1'b0, d_chk = 1'b0;
    int                     rd_cnt, wr_cnt, error_cnt = 0, n_tests = 0, cyc = 0;
    logic [31:0]            sh [logic [31:0]];
    sl1c_row_t rows [12] = '{
        '{1'b0, 4'h0, 32'h0, 32'h1000, 32'h1000, 8'h1, 8'h0},
        '{1'b1, 4'hF, 32'h11223344, 32'h1008, 32'h1008, 8'h1, 8'h0},
        '{1'b1, 4'h2, 32'h0000AA00, 32'h1008, 32'h1008, 8'h1, 8'h0},
        '{1'b0, 4'h0, 32'h0, 32'h1008, 32'h1008, 8'h1, 8'h0},
        '{1'b0, 4'h0, 32'h0, 32'h3000, 32'h3000, 8'h2, 8'h1},
        '{1'b0, 4'h0, 32'h0, 32'h1008, 32'h1008, 8'h3, 8'h1},
        '{1'b1, 4'hF, 32'h55667788, 32'h1C40, 32'h70040, 8'h4, 8'h1},
        '{1'b0, 4'h0, 32'h0, 32'h1C40, 32'h70040, 8'h4, 8'h1},
        '{1'b0, 4'h0, 32'h0, 32'h1C40, 32'h80040, 8'h5, 8'h2},
        '{1'b0, 4'h0, 32'h0, 32'h1FF0, 32'h1FF0, 8'h6, 8'h2},
        '{1'b0, 4'h0, 32'h0, 32'h3FF0, 32'h3FF0, 8'h7, 8'h2},
        '{1'b0, 4'h0, 32'h0, 32'h1FF0, 32'h1FF0, 8'h8, 8'h2}};
    always #25 clk = ~clk;
    sl1c_cache dut (.clk, .rst, .i_req, .i_req_data, .i_ready, .i_rvalid, .i_rdata, .d_req, .d_req_data,
        .d_ready, .d_rvalid, .d_rdata, .op_req, .op_req_data, .op_ready, .op_done, .mem_req, .mem_cmd,
        .mem_ack, .mem_rdata);
    sl1c_mem_model mem_i (.clk, .mem_req, .mem_cmd, .mem_ack, .mem_rdata, .lat, .rd_cnt, .wr_cnt);
    function automatic logic [31:0] ew(input logic [31:0] a);
        return sh.exists(a) ? sh[a] : a ^ 32'h5A5A0000;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bounded wait for 0 fetch ready, 1 data ready, 2 maintenance ready, 3 maintenance done
    task automatic await(input int s, input string what);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if ((s == 0 ? i_ready : s == 1 ? d_ready : s == 2 ? op_ready : op_done) === 1'b1)
                break;
        end
        if (k == 300)
            check(what, 32'h1, 32'h0);
    endtask
    task automatic dacc(input logic we, input logic [3:0] be, input logic [31:0] wd, va, pa);
        d_req <= 1'b1;
        d_req_data <= '{we, be, wd, va, pa};
        await(1, "d_ready");
    endtask
    task automatic dx(input logic we, input logic [3:0] be, input logic [31:0] wd, va, pa);
        dacc(we, be, wd, va, pa);
        d_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ifetch(input logic [31:0] a);
        i_req <= 1'b1;
        i_req_data <= '{a, a};
        await(0, "i_ready");
        i_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic op(input logic [1:0] c, input logic [31:0] va, pa);
        op_req <= 1'b1;
        op_req_data <= '{sl1c_pkg::sl1c_op_t'(c), va, pa};
        await(2, "op_ready");
        op_req <= 1'b0;
        await(3, "op_done");
    endtask
    // answers of taken loads and fetches, and the expected memory image of stores
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!rst) begin
            check("d_rvalid", {31'h0, d_chk}, {31'h0, d_rvalid});
            check("i_rvalid", {31'h0, i_chk}, {31'h0, i_rvalid});
            if (d_chk) check("d_rdata", d_exp, d_rdata);
            if (i_chk) check("i_rdata", i_exp, i_rdata);
        end
        d_chk <= d_req && d_ready && !d_req_data.we && !rst;
        i_chk <= i_req && i_ready && !rst;
        d_exp <= ew(d_req_data.paddr);
        i_exp <= ew(i_req_data.paddr);
        if (d_req && d_ready && d_req_data.we && !rst) begin
            w = ew(d_req_data.paddr);
            for (int b = 0; b < 4; b++)
                if (d_req_data.be[b]) w[8*b+:8] = d_req_data.wdata[8*b+:8];
            sh[d_req_data.paddr] = w;
        end
    end
    initial begin
        #(50 * 40000);
        error_cnt++;
        stop_test();
    end
    initial begin
        int r0, w0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 1024; k++) begin
            op(2'h0, 32'(k) << 4, 32'h0);
            if (k < 512) op(2'h1, 32'(k) << 4, 32'h0);
        end
        foreach (rows[k]) begin
            dx(rows[k].we, rows[k].be, rows[k].wd, rows[k].va, rows[k].pa);
            check("rd_cnt", 32'(rows[k].rd), rd_cnt);
            check("wr_cnt", 32'(rows[k].wr), wr_cnt);
        end
        $display("test rows done");
        lat <= 4'h7;
        r0 = rd_cnt;
        w0 = wr_cnt;
        r0 = r0 - cyc;
        dacc(1'b1, 4'hF, 32'hCAFE0001, 32'h1000, 32'h1000);
        dacc(1'b1, 4'hF, 32'hCAFE0002, 32'h1004, 32'h1004);
        dacc(1'b0, 4'h0, 32'h0, 32'h1004, 32'h1004);
        dacc(1'b0, 4'h0, 32'h0, 32'h1000, 32'h1000);
        d_req <= 1'b0;
        check("pipelined cycles", 32'd4, cyc + r0 - rd_cnt);
        r0 = rd_cnt;
        op(2'h2, 32'h1000, 32'h1000);
        check("wr_cnt", w0 + 1, wr_cnt);
        dx(1'b0, 4'h0, 32'h0, 32'h1004, 32'h1004);
        dx(1'b0, 4'h0, 32'h0, 32'h0500, 32'h0500);
        dx(1'b1, 4'hF, 32'hBEEF0000, 32'h0500, 32'h0500);
        op(2'h3, 32'h0500, 32'h0500);
        sh.delete(32'h0500);
        dx(1'b0, 4'h0, 32'h0, 32'h0500, 32'h0500);
        op(2'h1, 32'h0500, 32'h0);
        dx(1'b0, 4'h0, 32'h0, 32'h0500, 32'h0500);
        check("rd_cnt", r0 + 4, rd_cnt);
        check("wr_cnt", w0 + 1, wr_cnt);
        $display("test maintenance done");
        r0 = rd_cnt;
        ifetch(32'h0);
        ifetch(32'h2000);
        ifetch(32'h0);
        ifetch(32'h2000);
        check("rd_cnt", r0 + 2, rd_cnt);
        op(2'h0, 32'h0, 32'h0);
        ifetch(32'h0);
        check("rd_cnt", r0 + 3, rd_cnt);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        ifetch(32'h2000);
        dx(1'b0, 4'h0, 32'h0, 32'h1FF0, 32'h1FF0);
        check("rd_cnt", r0 + 3, rd_cnt);
        $display("test fetch and reset done");
        stop_test();
    end
endmodule

// ---- common/sl1c_pkg.sv ----
// shared constants and carrier types of the split level-one cache
package sl1c_pkg;
    localparam int LINE_WORDS   = 4;
    localparam int LINE_BYTES   = 16;
    localparam int LINE_W       = LINE_WORDS * 32;
    localparam int IDX_LSB      = 4;
    localparam int TAG_LSB      = 10;
    localparam int TAG_W        = 22;
    localparam int PAGE_IDX_W   = TAG_LSB - IDX_LSB;
    localparam int I_SIZE_BYTES = 16384;
    localparam int D_SIZE_BYTES = 8192;
    localparam int I_IDX_W      = $clog2(I_SIZE_BYTES / LINE_BYTES);
    localparam int D_IDX_W      = $clog2(D_SIZE_BYTES / LINE_BYTES);
    localparam int I_FLAG_W     = 1;
    localparam int D_FLAG_W     = 3;
    localparam int I_ENTRY_W    = TAG_W + I_FLAG_W;
    localparam int D_ENTRY_W    = TAG_W + D_FLAG_W;
    localparam int FLAG_V       = 0;
    localparam int FLAG_D       = 1;
    localparam int FLAG_WR      = 2;

    typedef enum logic [1:0] {
        SL1C_IDLE  = 2'b00,
        SL1C_WBACK = 2'b01,
        SL1C_FILL  = 2'b10
    } sl1c_state_t;

    typedef enum logic [1:0] {
        SL1C_OP_I_INV    = 2'b00,
        SL1C_OP_D_INV    = 2'b01,
        SL1C_OP_D_WBINV  = 2'b10,
        SL1C_OP_D_HITINV = 2'b11
    } sl1c_op_t;

    typedef struct packed {
        logic [31:0] vaddr;
        logic [31:0] paddr;
    } sl1c_ireq_t;

    typedef struct packed {
        logic        we;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic [31:0] vaddr;
        logic [31:0] paddr;
    } sl1c_dreq_t;

    typedef struct packed {
        sl1c_op_t    code;
        logic [31:0] vaddr;
        logic [31:0] paddr;
    } sl1c_opreq_t;

    typedef struct packed {
        logic              we;
        logic [31:0]       addr;
        logic [LINE_W-1:0] wdata;
    } sl1c_memreq_t;
endpackage

// ---- hw/sl1c_array.sv ----
// direct-mapped tag and data storage of one cache, one tag entry per line
`timescale 1ns/1ns
module sl1c_array #(
    parameter int IDX_W  = 9,
    parameter int FLAG_W = 3
) (
    input  wire logic                            clk,
    input  wire logic [IDX_W-1:0]                rd_idx,
    output logic [sl1c_pkg::TAG_W-1:0]           rd_tag,
    output logic [FLAG_W-1:0]                    rd_flags,
    output logic [sl1c_pkg::LINE_W-1:0]          rd_line,
    input  wire logic                            wr_en,
    input  wire logic [IDX_W-1:0]                wr_idx,
    input  wire logic [sl1c_pkg::TAG_W-1:0]      wr_tag,
    input  wire logic [FLAG_W-1:0]               wr_flags,
    input  wire logic [sl1c_pkg::LINE_W-1:0]     wr_line,
    input  wire logic [sl1c_pkg::LINE_BYTES-1:0] wr_mask
);
    localparam int LINES = 1 << IDX_W;

    logic [sl1c_pkg::TAG_W-1:0]  tag_mem  [LINES];
    logic [FLAG_W-1:0]           flag_mem [LINES];
    logic [sl1c_pkg::LINE_W-1:0] data_mem [LINES];

    assign rd_tag   = tag_mem[rd_idx];
    assign rd_flags = flag_mem[rd_idx];
    assign rd_line  = data_mem[rd_idx];

    // no reset here: line state survives reset until software invalidates it
    always_ff @(posedge clk) begin
        if (wr_en) begin
            tag_mem[wr_idx]  <= wr_tag;
            flag_mem[wr_idx] <= wr_flags;
            for (int b = 0; b < sl1c_pkg::LINE_BYTES; b++) begin
                if (wr_mask[b]) begin
                    data_mem[wr_idx][8*b +: 8] <= wr_line[8*b +: 8];
                end
            end
        end
    end
endmodule

// ---- hw/sl1c_cache.sv ----
// split instruction and write-back data cache with line refill controller
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module sl1c_cache (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           i_req,
    input  wire sl1c_pkg::sl1c_ireq_t           i_req_data,
    output logic                                i_ready,
    output logic                                i_rvalid,
    output logic [31:0]                         i_rdata,
    input  wire logic                           d_req,
    input  wire sl1c_pkg::sl1c_dreq_t           d_req_data,
    output logic                                d_ready,
    output logic                                d_rvalid,
    output logic [31:0]                         d_rdata,
    input  wire logic                           op_req,
    input  wire sl1c_pkg::sl1c_opreq_t          op_req_data,
    output logic                                op_ready,
    output logic                                op_done,
    output logic                                mem_req,
    output sl1c_pkg::sl1c_memreq_t              mem_cmd,
    input  wire logic                           mem_ack,
    input  wire logic [sl1c_pkg::LINE_W-1:0]    mem_rdata
);
    localparam int IW = sl1c_pkg::I_IDX_W;
    localparam int DW = sl1c_pkg::D_IDX_W;
    localparam int TW = sl1c_pkg::TAG_W;
    localparam int LW = sl1c_pkg::LINE_W;
    localparam int FW = sl1c_pkg::D_FLAG_W;
    localparam logic [FW-1:0] D_CLEAN   = 3'h1;
    localparam logic [FW-1:0] D_STORED  = 3'h7;
    localparam logic [FW-1:0] D_INVALID = 3'h0;

    typedef struct packed {
        sl1c_pkg::sl1c_state_t  fsm;
        logic                   sel_d;
        logic                   is_op;
        logic [31:0]            vaddr;
        logic [31:0]            paddr;
        logic                   mem_req;
        sl1c_pkg::sl1c_memreq_t mem_cmd;
        logic                   st2_v;
        logic [DW-1:0]          st2_idx;
        logic [TW-1:0]          st2_tag;
        logic [1:0]             st2_word;
        logic [31:0]            st2_data;
        logic [3:0]             st2_be;
        logic                   i_rvalid;
        logic [31:0]            i_rdata;
        logic                   d_rvalid;
        logic [31:0]            d_rdata;
        logic                   op_done;
    } sl1c_core_t;

    sl1c_core_t st;
    sl1c_core_t next_st;

    logic [IW-1:0]                   i_rd_idx;
    logic [TW-1:0]                   i_tag;
    logic [sl1c_pkg::I_FLAG_W-1:0]   i_flags;
    logic [LW-1:0]                   i_line;
    logic                            i_wr_en;
    logic [sl1c_pkg::I_FLAG_W-1:0]   i_wr_flags;
    logic [LW-1:0]                   i_wr_line;
    logic [sl1c_pkg::LINE_BYTES-1:0] i_wr_mask;
    logic [IW-1:0]                   i_wr_idx;
    logic [TW-1:0]                   i_wr_tag;
    logic [DW-1:0]                   d_rd_idx;
    logic [TW-1:0]                   d_tag;
    logic [FW-1:0]                   d_flags;
    logic [LW-1:0]                   d_line;
    logic                            d_wr_en;
    logic [DW-1:0]                   d_wr_idx;
    logic [TW-1:0]                   d_wr_tag;
    logic [FW-1:0]                   d_wr_flags;
    logic [LW-1:0]                   d_wr_line;
    logic [sl1c_pkg::LINE_BYTES-1:0] d_wr_mask;
    logic                            i_hit;
    logic                            d_hit;
    logic                            op_hit;
    logic                            d_fire;
    logic                            op_fire;
    logic                            d_miss_start;
    logic                            i_miss_start;
    logic [31:0]                     i_word;
    logic [31:0]                     d_word;

    // instruction cache: 1024 lines, tag entry of I_ENTRY_W bits
    sl1c_array #(.IDX_W(IW), .FLAG_W(sl1c_pkg::I_FLAG_W)) icache (
        .clk      (clk),
        .rd_idx   (i_rd_idx),
        .rd_tag   (i_tag),
        .rd_flags (i_flags),
        .rd_line  (i_line),
        .wr_en    (i_wr_en),
        .wr_idx   (i_wr_idx),
        .wr_tag   (i_wr_tag),
        .wr_flags (i_wr_flags),
        .wr_line  (i_wr_line),
        .wr_mask  (i_wr_mask)
    );

    // data cache: 512 lines, tag entry of D_ENTRY_W bits
    sl1c_array #(.IDX_W(DW), .FLAG_W(FW)) dcache (
        .clk      (clk),
        .rd_idx   (d_rd_idx),
        .rd_tag   (d_tag),
        .rd_flags (d_flags),
        .rd_line  (d_line),
        .wr_en    (d_wr_en),
        .wr_idx   (d_wr_idx),
        .wr_tag   (d_wr_tag),
        .wr_flags (d_wr_flags),
        .wr_line  (d_wr_line),
        .wr_mask  (d_wr_mask)
    );

    // virtual index selects the line, physical tag decides the hit
    always_comb begin
        if (st.fsm != sl1c_pkg::SL1C_IDLE) begin
            i_rd_idx = st.vaddr[sl1c_pkg::IDX_LSB +: IW];
            d_rd_idx = st.vaddr[sl1c_pkg::IDX_LSB +: DW];
        end else begin
            i_rd_idx = i_req_data.vaddr[sl1c_pkg::IDX_LSB +: IW];
            d_rd_idx = d_req ? d_req_data.vaddr[sl1c_pkg::IDX_LSB +: DW]
                             : op_req_data.vaddr[sl1c_pkg::IDX_LSB +: DW];
        end
    end

    assign i_hit  = i_flags[sl1c_pkg::FLAG_V] && (i_tag == i_req_data.paddr[31:sl1c_pkg::TAG_LSB]);
    assign d_hit  = d_flags[sl1c_pkg::FLAG_V] && (d_tag == d_req_data.paddr[31:sl1c_pkg::TAG_LSB]);
    assign op_hit = d_flags[sl1c_pkg::FLAG_V] && (d_tag == op_req_data.paddr[31:sl1c_pkg::TAG_LSB]);

    // a fetch or data request is only taken once its line is resident
    assign i_ready  = (st.fsm == sl1c_pkg::SL1C_IDLE) && (!i_req || i_hit);
    assign d_ready  = (st.fsm == sl1c_pkg::SL1C_IDLE) && (!d_req || d_hit);
    assign op_ready = (st.fsm == sl1c_pkg::SL1C_IDLE) && !st.st2_v && !d_req;
    assign d_fire   = d_req && d_ready;
    assign op_fire  = op_req && op_ready;
    // misses wait for a pending store so the victim read sees its data
    assign d_miss_start = (st.fsm == sl1c_pkg::SL1C_IDLE) && d_req && !d_hit && !st.st2_v;
    assign i_miss_start = (st.fsm == sl1c_pkg::SL1C_IDLE) && i_req && !i_hit && !st.st2_v
                          && !(d_req && !d_hit) && !op_fire;

    assign i_word = i_line[{i_req_data.vaddr[3:2], 5'h00} +: 32];

    // load data, with bytes of the store still in its write stage forwarded
    always_comb begin
        d_word = d_line[{d_req_data.vaddr[3:2], 5'h00} +: 32];
        if (st.st2_v && st.st2_idx == d_req_data.vaddr[sl1c_pkg::IDX_LSB +: DW]
            && st.st2_word == d_req_data.vaddr[3:2]) begin
            for (int b = 0; b < 4; b++) begin
                if (st.st2_be[b]) begin
                    d_word[8*b +: 8] = st.st2_data[8*b +: 8];
                end
            end
        end
    end

    // single write port per array; sources never overlap in one cycle
    always_comb begin
        i_wr_en    = 1'b0;
        i_wr_idx   = st.vaddr[sl1c_pkg::IDX_LSB +: IW];
        i_wr_tag   = st.paddr[31:sl1c_pkg::TAG_LSB];
        i_wr_flags = '0;
        i_wr_line  = mem_rdata;
        i_wr_mask  = '0;
        d_wr_en    = 1'b0;
        d_wr_idx   = st.vaddr[sl1c_pkg::IDX_LSB +: DW];
        d_wr_tag   = st.paddr[31:sl1c_pkg::TAG_LSB];
        d_wr_flags = D_INVALID;
        d_wr_line  = mem_rdata;
        d_wr_mask  = '0;
        if (st.st2_v) begin
            d_wr_en    = 1'b1;
            d_wr_idx   = st.st2_idx;
            d_wr_tag   = st.st2_tag;
            d_wr_flags = D_STORED;
            d_wr_line  = {sl1c_pkg::LINE_WORDS{st.st2_data}};
            d_wr_mask  = {12'h000, st.st2_be} << {st.st2_word, 2'b00};
        end else if (st.fsm == sl1c_pkg::SL1C_FILL && mem_ack) begin
            // whole line lands at once, clean
            if (st.sel_d) begin
                d_wr_en    = 1'b1;
                d_wr_flags = D_CLEAN;
                d_wr_mask  = '1;
            end else begin
                i_wr_en    = 1'b1;
                i_wr_flags = 1'b1;
                i_wr_mask  = '1;
            end
        end else if (st.fsm == sl1c_pkg::SL1C_WBACK && mem_ack && st.is_op) begin
            d_wr_en  = 1'b1;
            d_wr_tag = d_tag;
        end else if (op_fire) begin
            d_wr_idx = op_req_data.vaddr[sl1c_pkg::IDX_LSB +: DW];
            d_wr_tag = d_tag;
            i_wr_idx = op_req_data.vaddr[sl1c_pkg::IDX_LSB +: IW];
            i_wr_tag = op_req_data.paddr[31:sl1c_pkg::TAG_LSB];
            case (op_req_data.code)
                sl1c_pkg::SL1C_OP_I_INV:    i_wr_en = 1'b1;
                sl1c_pkg::SL1C_OP_D_INV:    d_wr_en = 1'b1;
                sl1c_pkg::SL1C_OP_D_HITINV: d_wr_en = op_hit;
                sl1c_pkg::SL1C_OP_D_WBINV:
                    d_wr_en = !(d_flags[sl1c_pkg::FLAG_V] && d_flags[sl1c_pkg::FLAG_D]);
                default:                    d_wr_en = 1'b0;
            endcase
        end
    end

    always_comb begin
        next_st          = st;
        next_st.i_rvalid = i_req && i_ready;
        next_st.d_rvalid = d_fire && !d_req_data.we;
        next_st.op_done  = 1'b0;
        next_st.st2_v    = d_fire && d_req_data.we;
        if (i_req && i_ready) begin
            next_st.i_rdata = i_word;
        end
        if (d_fire && !d_req_data.we) begin
            next_st.d_rdata = d_word;
        end
        if (d_fire && d_req_data.we) begin
            // stage one: tag already checked, capture the write
            next_st.st2_idx  = d_req_data.vaddr[sl1c_pkg::IDX_LSB +: DW];
            next_st.st2_tag  = d_req_data.paddr[31:sl1c_pkg::TAG_LSB];
            next_st.st2_word = d_req_data.vaddr[3:2];
            next_st.st2_data = d_req_data.wdata;
            next_st.st2_be   = d_req_data.be;
        end
        case (st.fsm)
            sl1c_pkg::SL1C_IDLE: begin
                if (d_miss_start || i_miss_start) begin
                    next_st.sel_d         = d_miss_start;
                    next_st.is_op         = 1'b0;
                    next_st.vaddr         = d_miss_start ? d_req_data.vaddr : i_req_data.vaddr;
                    next_st.paddr         = d_miss_start ? d_req_data.paddr : i_req_data.paddr;
                    next_st.mem_req       = 1'b1;
                    next_st.mem_cmd.we    = 1'b0;
                    next_st.mem_cmd.addr  = d_miss_start ? {d_req_data.paddr[31:4], 4'h0}
                                                         : {i_req_data.paddr[31:4], 4'h0};
                    next_st.mem_cmd.wdata = d_line;
                    next_st.fsm           = sl1c_pkg::SL1C_FILL;
                    if (d_miss_start && d_flags[sl1c_pkg::FLAG_V] && d_flags[sl1c_pkg::FLAG_D]) begin
                        next_st.mem_cmd.we   = 1'b1;
                        next_st.mem_cmd.addr = {d_tag, d_rd_idx[sl1c_pkg::PAGE_IDX_W-1:0], 4'h0};
                        next_st.fsm          = sl1c_pkg::SL1C_WBACK;
                    end
                end else if (op_fire) begin
                    if (op_req_data.code == sl1c_pkg::SL1C_OP_D_WBINV
                        && d_flags[sl1c_pkg::FLAG_V] && d_flags[sl1c_pkg::FLAG_D]) begin
                        next_st.sel_d         = 1'b1;
                        next_st.is_op         = 1'b1;
                        next_st.vaddr         = op_req_data.vaddr;
                        next_st.paddr         = op_req_data.paddr;
                        next_st.mem_req       = 1'b1;
                        next_st.mem_cmd.we    = 1'b1;
                        next_st.mem_cmd.addr  = {d_tag, d_rd_idx[sl1c_pkg::PAGE_IDX_W-1:0], 4'h0};
                        next_st.mem_cmd.wdata = d_line;
                        next_st.fsm           = sl1c_pkg::SL1C_WBACK;
                    end else begin
                        next_st.op_done = 1'b1;
                    end
                end
            end
            sl1c_pkg::SL1C_WBACK: begin
                if (mem_ack) begin
                    if (st.is_op) begin
                        next_st.mem_req = 1'b0;
                        next_st.op_done = 1'b1;
                        next_st.fsm     = sl1c_pkg::SL1C_IDLE;
                    end else begin
                        next_st.mem_cmd.we   = 1'b0;
                        next_st.mem_cmd.addr = {st.paddr[31:4], 4'h0};
                        next_st.fsm          = sl1c_pkg::SL1C_FILL;
                    end
                end
            end
            sl1c_pkg::SL1C_FILL: begin
                if (mem_ack) begin
                    next_st.mem_req = 1'b0;
                    next_st.fsm     = sl1c_pkg::SL1C_IDLE;
                end
            end
            default: begin
                next_st.mem_req = 1'b0;
                next_st.fsm     = sl1c_pkg::SL1C_IDLE;
            end
        endcase
    end

    // control only; the arrays keep their line state through reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign i_rvalid = st.i_rvalid;
    assign i_rdata  = st.i_rdata;
    assign d_rvalid = st.d_rvalid;
    assign d_rdata  = st.d_rdata;
    assign op_done  = st.op_done;
    assign mem_req  = st.mem_req;
    assign mem_cmd  = st.mem_cmd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence store_taken;
        d_fire && d_req_data.we;
    endsequence
    sequence stage_two_write;
        d_wr_en && d_wr_flags == D_STORED && !(st.mem_req && st.mem_cmd.we);
    endsequence

    load_hit_a: assert property (d_fire && !d_req_data.we |=> st.d_rvalid && d_rdata == $past(d_word))
        else $error("data load hit not answered in one cycle");
    ifetch_hit_a: assert property (i_req && i_ready |=> i_rvalid && i_rdata == $past(i_word))
        else $error("instruction hit not answered in one cycle");
    store_pipe_a: assert property (store_taken |=> stage_two_write)
        else $error("store data not written in second stage");
    store_back_a: assert property (store_taken ##1 store_taken |=> stage_two_write)
        else $error("back to back stores not sustained");
    no_through_a: assert property (st.st2_v |-> !(st.mem_req && st.mem_cmd.we))
        else $error("store hit reached memory");
    taken_hit_a: assert property (d_fire
        |-> d_flags[sl1c_pkg::FLAG_V] && d_rd_idx == d_req_data.vaddr[sl1c_pkg::IDX_LSB +: DW])
        else $error("data access taken without resident line");
    miss_fetch_a: assert property (i_miss_start |=> st.fsm == sl1c_pkg::SL1C_FILL && mem_req && !mem_cmd.we)
        else $error("instruction miss did not start refill");
    wb_only_a: assert property (mem_req && mem_cmd.we |-> st.fsm == sl1c_pkg::SL1C_WBACK)
        else $error("memory write outside writeback");
    victim_wb_a: assert property (d_miss_start && d_flags == D_STORED |=> mem_req && mem_cmd.we)
        else $error("dirty victim not written back");
    wb_fill_a: assert property (st.fsm == sl1c_pkg::SL1C_WBACK && mem_ack && !st.is_op
        |=> st.fsm == sl1c_pkg::SL1C_FILL && !mem_cmd.we)
        else $error("refill did not follow victim writeback");
    wb_inval_a: assert property (st.fsm == sl1c_pkg::SL1C_WBACK && mem_ack && st.is_op
        |-> d_wr_en && d_wr_flags == D_INVALID ##1 op_done)
        else $error("line kept valid after writeback");
    fill_clean_a: assert property (st.fsm == sl1c_pkg::SL1C_FILL && mem_ack && st.sel_d
        |-> d_wr_en && d_wr_flags == D_CLEAN && d_wr_mask == '1)
        else $error("refilled data line not valid clean");
endmodule
